// ---- hdl/rocof_consts.svh ----
// Purpose: Constants of the rate-of-change-of-frequency element.
// Assumes: 50 MHz system clock.
// Notes:   Timing counts are derived from the clock rate.
`ifndef ROCOF_CONSTS_SVH
`define ROCOF_CONSTS_SVH

// System clock rate in hertz and the millisecond tick count.
`define CLK_HZ        32'h02FA_F080
`define MS_CYC_DEF    (`CLK_HZ / 32'h0000_03E8)
// Comparator filter delay in milliseconds.
`define FILTER_MS     14'h0064
// Trip delay setting range and default in milliseconds.
`define TRIP_MIN_MS   14'h00C8
`define TRIP_MAX_MS   14'h2710
`define TRIP_DEF_MS   14'h00C8
// Threshold range and default in steps of 0.01 Hz/s.
`define THR_MAX       11'sh1F4
`define THR_DEF       11'sh032
// Above this threshold magnitude the wider drop-out ratio applies.
`define DROP_KNEE     11'sh032
// Drop-out ratios in thousandths.
`define DROP_HI       64'sh0398
`define DROP_LO       64'sh03E7
`define RATIO_DEN     64'sh03E8
// Consecutive measurements needed to accept or to drop frequency.
`define ACCEPT_CNT    3'h4
// History depth in half periods: five whole periods.
`define HIST_DEPTH    4'hA
// Clock rate times 1000, divided by a period gives millihertz.
`define FREQ_NUM      40'hB_A43B_7400
// Scale that turns mHz over clock cycles into 0.01 Hz/s units.
`define RATE_SCALE    (`CLK_HZ / 32'h0000_000A)
// Accepted frequency band in hertz, turned into period limits.
`define F_HIGH_HZ     32'h0000_0046
`define F_LOW_HZ      32'h0000_0028
`define PER_MIN_DEF   (`CLK_HZ / `F_HIGH_HZ)
`define PER_MAX_DEF   (`CLK_HZ / `F_LOW_HZ)

`endif

// ---- hdl/rocof_pkg.sv ----
// Purpose: Types shared by the rate-of-change-of-frequency element.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only.
package rocof_pkg;
  // Sequence of one measurement from crossing to evaluation.
  typedef enum logic [1:0] {MS_IDLE, MS_DIV, MS_READ, MS_EVAL} meas_state_t;
  // One signed voltage sample.
  typedef logic signed [15:0] sample_t;
  // Frequency in millihertz.
  typedef logic [19:0] freq_t;
endpackage : rocof_pkg

// ---- hdl/rocof_meas_if.sv ----
// Purpose: Carries one zero-crossing measurement to the evaluator.
// Assumes: Single clock domain.
// Notes:   All fields are valid in the cycle evt is high, except period after a timeout, which leaves period unchanged.
`timescale 1ns/1ps
interface rocof_meas_if;
  logic        evt;     // One-cycle measurement pulse.
  logic        ok;      // Rising and falling periods both lie inside the band.
  logic [21:0] period;  // Mean of rising and falling periods.
  logic [31:0] ts;      // Cycle stamp of the crossing.
  logic [15:0] peak;    // Peak magnitude of the last half cycle.
  modport src (output evt, ok, period, ts, peak);
  modport snk (input evt, ok, period, ts, peak);
endinterface : rocof_meas_if

// ---- hdl/rocof_period_meter.sv ----
// Purpose: Times rising and falling zero crossings of a sample stream.
// Assumes: Samples arrive with a one-cycle strobe.
// Notes:   A missing crossing beyond the longest period is reported.
`timescale 1ns/1ps
`include "rocof_consts.svh"
module rocof_period_meter
  import rocof_pkg::*;
#(
  parameter int PER_MIN = `PER_MIN_DEF,
  parameter int PER_MAX = `PER_MAX_DEF
) (
  // Clock and reset.
  input  wire logic    i_clk,
  input  wire logic    i_reset_n,
  // Sample stream.
  input  wire logic    i_smp,
  input  wire sample_t i_v,
  // Measurement out.
  rocof_meas_if.src    m
);
  logic [31:0] ts_r;          // Free-running cycle stamp.
  logic        neg_r;         // Sign of the previous sample.
  logic [31:0] lrise_r;       // Stamp of the last rising crossing.
  logic [31:0] lfall_r;       // Stamp of the last falling crossing.
  logic [31:0] lx_r;          // Stamp of the last crossing or timeout.
  logic [21:0] prise_r;       // Last rising-to-rising period.
  logic [21:0] pfall_r;       // Last falling-to-falling period.
  logic [15:0] peak_r;        // Running peak of the half cycle.

  wire         rise_x = i_smp & neg_r & ~i_v[15];
  wire         fall_x = i_smp & ~neg_r & i_v[15];
  wire         tmo    = (ts_r - lx_r) >= 32'(PER_MAX);
  wire  [31:0] pnew   = ts_r - (rise_x ? lrise_r : lfall_r);
  wire  [21:0] pnew_c = (pnew > 32'(PER_MAX)) ? 22'(PER_MAX) : pnew[21:0];
  wire  [21:0] pother = rise_x ? pfall_r : prise_r;
  wire  [22:0] psum   = {1'b0, pnew_c} + {1'b0, pother};
  wire  [15:0] vabs   = i_v[15] ? 16'(-i_v) : 16'(i_v);
  wire         in_rng = (pnew_c >= 22'(PER_MIN)) && (pother >= 22'(PER_MIN))
                        && (pother <= 22'(PER_MAX)) && (pnew <= 32'(PER_MAX));

  // Time both polarities and publish the mean at every crossing.
  // separate rise and fall periods
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ts_r     <= 32'h0000_0000;
      neg_r    <= 1'b0;
      lrise_r  <= 32'h0000_0000;
      lfall_r  <= 32'h0000_0000;
      lx_r     <= 32'h0000_0000;
      prise_r  <= 22'h00_0000;
      pfall_r  <= 22'h00_0000;
      peak_r   <= 16'h0000;
      m.evt    <= 1'b0;
      m.ok     <= 1'b0;
      m.period <= 22'h00_0000;
      m.ts     <= 32'h0000_0000;
      m.peak   <= 16'h0000;
    end else begin
      ts_r  <= ts_r + 32'h0000_0001;
      m.evt <= 1'b0;
      if (i_smp) begin
        neg_r <= i_v[15];
        if (vabs > peak_r) begin
          peak_r <= vabs;
        end
      end
      if (rise_x || fall_x) begin
        // A crossing: close this polarity's period and emit the mean.
        if (rise_x) begin
          lrise_r <= ts_r;
          prise_r <= pnew_c;
        end else begin
          lfall_r <= ts_r;
          pfall_r <= pnew_c;
        end
        lx_r     <= ts_r;
        peak_r   <= vabs;
        m.evt    <= 1'b1;
        m.ok     <= in_rng;
        m.period <= psum[22:1];
        m.ts     <= ts_r;
        m.peak   <= peak_r;
      end else if (tmo) begin
        // No crossing for too long: report an invalid measurement.
        lx_r     <= ts_r;
        prise_r  <= 22'h00_0000;
        pfall_r  <= 22'h00_0000;
        peak_r   <= 16'h0000;
        m.evt    <= 1'b1;
        m.ok     <= 1'b0;
        m.ts     <= ts_r;
        m.peak   <= peak_r;
      end
    end
  end
endmodule : rocof_period_meter

// ---- hdl/rocof_history.sv ----
// Purpose: Small memory of past frequency values and their stamps.
// Assumes: One write and one read port on the same clock.
// Notes:   Read data come out of a register one cycle after the read.
`timescale 1ns/1ps
module rocof_history #(
  parameter int W  = 52,
  parameter int D  = 10,
  parameter int AW = 4
) (
  // Clock and reset.
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  // Write port.
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  // Read port.
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);
  logic [W-1:0] mem [D];  // Storage, no reset needed.

  // Write the new entry.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : rocof_history

// ---- hdl/rocof_protection.sv ----
// Purpose: Rate-of-change-of-frequency start and trip element.
// Assumes: Voltage samples arrive as a strobe with signed data.
// Notes:   Frequency is in mHz, thresholds in 0.01 Hz/s steps.
`timescale 1ns/1ps
`include "rocof_consts.svh"
module rocof_protection
  import rocof_pkg::*;
#(
  parameter int          MS_CYCLES  = `MS_CYC_DEF,
  parameter int          PER_MIN    = `PER_MIN_DEF,
  parameter int          PER_MAX    = `PER_MAX_DEF,
  parameter logic [15:0] RATED_PEAK = 16'h7000
) (
  // Clock and reset.
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  // Voltage samples.
  input  wire logic                i_sample_valid,
  input  wire sample_t             i_volt_line,
  input  wire sample_t             i_volt_bus,
  // Settings.
  input  wire logic                i_src_bus,
  input  wire logic                i_enable,
  input  wire logic                i_start_only,
  input  wire logic signed [10:0]  i_rate_threshold_setting,
  input  wire logic        [13:0]  i_trip_delay_ms,
  // Blocking from surrounding logic.
  input  wire logic                i_block,
  // Element outputs.
  output logic                     o_general_start_out,
  output logic                     o_general_trip_out,
  // Transition events.
  output logic                     o_start_event,
  output logic                     o_trip_event,
  // Measurement status.
  output freq_t                    o_freq_mhz,
  output logic                     o_freq_valid
);
  localparam int HD = 10;  // History depth in half periods.

  rocof_meas_if meas ();   // Crossing measurements.

  wire sample_t v_sel = i_src_bus ? i_volt_bus : i_volt_line;

  rocof_period_meter #(
    .PER_MIN   (PER_MIN),
    .PER_MAX   (PER_MAX)
  ) u_meter (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_smp     (i_sample_valid),
    .i_v       (v_sel),
    .m         (meas.src)
  );

  meas_state_t  st_r;      // Measurement sequence state.
  logic [22:0]  rem_r;     // Divider partial remainder.
  logic [39:0]  num_r;     // Divider numerator, shifted out.
  logic [21:0]  dvs_r;     // Divider divisor: the mean period.
  logic [19:0]  quo_r;     // Divider quotient.
  logic [5:0]   bit_r;     // Divider step count.
  logic [31:0]  tsx_r;     // Stamp of the crossing being handled.
  logic         vok_r;     // Voltage above the minimum.
  logic [2:0]   vcnt_r;    // Consecutive valid measurements.
  logic [2:0]   icnt_r;    // Consecutive invalid measurements.
  freq_t        freq_r;    // Held frequency in mHz.
  logic         acc_r;     // Frequency accepted.
  logic [3:0]   hptr_r;    // History slot of the oldest entry.
  logic [3:0]   fill_r;    // History entries present.
  logic         cond_r;    // Rate condition with hysteresis.
  logic [51:0]  hrd;       // History read data.
  logic [16:0]  ms_cnt_r;  // Millisecond divider.
  logic         ms_tick_r; // One-cycle millisecond enable.
  logic [13:0]  elap_r;    // Milliseconds since fault onset.

  // Divider step: shift in one numerator bit and try to subtract.
  wire [22:0] rem_sh = {rem_r[21:0], num_r[39]};
  wire        sub_ok = rem_sh >= {1'b0, dvs_r};
  wire [22:0] rem_nx = sub_ok ? rem_sh - {1'b0, dvs_r} : rem_sh;
  wire        div_end = (bit_r == 6'h27);

  wire [15:0] vmin = RATED_PEAK / 16'h000A;

  wire signed [10:0] thr =
    (i_rate_threshold_setting > `THR_MAX)  ? `THR_MAX :
    (i_rate_threshold_setting < -`THR_MAX) ? -`THR_MAX :
    i_rate_threshold_setting;
  wire        thr_neg = thr[10];
  wire [10:0] thr_abs = thr_neg ? 11'(-thr) : 11'(thr);

  wire [13:0] dly =
    (i_trip_delay_ms < `TRIP_MIN_MS) ? `TRIP_MIN_MS :
    (i_trip_delay_ms > `TRIP_MAX_MS) ? `TRIP_MAX_MS : i_trip_delay_ms;

  wire freq_t        f_old = hrd[19:0];
  wire        [23:0] e_cyc = tsx_r[23:0] - hrd[43:20];
  wire signed [20:0] df    = $signed({1'b0, freq_r}) - $signed({1'b0, f_old});

  // Rate test without division: df*CLK/10 against thr*cycles.
  wire signed [47:0] lhs = $signed(48'(df)) * $signed(48'(`RATE_SCALE));
  wire signed [47:0] rhs = $signed(48'(thr)) * $signed(48'({1'b0, e_cyc}));
  wire signed [47:0] lo  = thr_neg ? -lhs : lhs;
  wire signed [47:0] ro  = thr_neg ? -rhs : rhs;
  wire               pick = lo > ro;
  wire signed [63:0] ratio = (thr_abs > 11'(`DROP_KNEE)) ? `DROP_HI
                                                          : `DROP_LO;
  wire               hold =
    ($signed(64'(lo)) * `RATIO_DEN) >= ($signed(64'(ro)) * ratio);

  wire hist_full = (fill_r == `HIST_DEPTH);
  wire hist_rd   = (st_r == MS_READ);
  wire hist_wr   = (st_r == MS_EVAL);

  rocof_history #(
    .W         (52),
    .D         (HD),
    .AW        (4)
  ) u_hist (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_we      (hist_wr),
    .i_waddr   (hptr_r),
    .i_wdata   ({tsx_r[31:0], freq_r}),
    .i_re      (hist_rd),
    .i_raddr   (hptr_r),
    .o_rdata   (hrd)
  );

  // Measurement sequence: divide, qualify, read history, evaluate.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r   <= MS_IDLE;
      rem_r  <= 23'h00_0000;
      num_r  <= 40'h00_0000_0000;
      dvs_r  <= 22'h00_0000;
      quo_r  <= 20'h0_0000;
      bit_r  <= 6'h00;
      tsx_r  <= 32'h0000_0000;
      vok_r  <= 1'b0;
      vcnt_r <= 3'h0;
      icnt_r <= 3'h0;
      freq_r <= 20'h0_0000;
      acc_r  <= 1'b0;
      hptr_r <= 4'h0;
      fill_r <= 4'h0;
      cond_r <= 1'b0;
    end else begin
      case (st_r)
        MS_IDLE: begin
          if (meas.evt) begin
            tsx_r <= meas.ts;
            vok_r <= meas.peak > vmin;
            if (meas.peak <= vmin) begin
              cond_r <= 1'b0;
            end
            if (meas.ok) begin
              rem_r <= 23'h00_0000;
              num_r <= `FREQ_NUM;
              dvs_r <= meas.period;
              bit_r <= 6'h00;
              st_r  <= MS_DIV;
            end else begin
              vcnt_r <= 3'h0;
              if (icnt_r != `ACCEPT_CNT) begin
                icnt_r <= icnt_r + 3'h1;
              end
              if (icnt_r == `ACCEPT_CNT - 3'h1) begin
                freq_r <= 20'h0_0000;
                acc_r  <= 1'b0;
                fill_r <= 4'h0;
                cond_r <= 1'b0;
              end
            end
          end
        end
        MS_DIV: begin
          rem_r <= rem_nx;
          num_r <= {num_r[38:0], 1'b0};
          quo_r <= {quo_r[18:0], sub_ok};
          bit_r <= bit_r + 6'h01;
          if (div_end) begin
            icnt_r <= 3'h0;
            if (vcnt_r != `ACCEPT_CNT) begin
              vcnt_r <= vcnt_r + 3'h1;
            end
            if (vcnt_r >= `ACCEPT_CNT - 3'h1) begin
              freq_r <= {quo_r[18:0], sub_ok};
              acc_r  <= 1'b1;
              st_r   <= MS_READ;
            end else begin
              st_r <= MS_IDLE;
            end
          end
        end
        MS_READ: begin
          // History read issued; data arrive next cycle.
          st_r <= MS_EVAL;
        end
        MS_EVAL: begin
          if (hist_full) begin
            cond_r <= vok_r & (cond_r ? hold : pick);
          end else begin
            cond_r <= 1'b0;
            fill_r <= fill_r + 4'h1;
          end
          hptr_r <= (hptr_r == `HIST_DEPTH - 4'h1) ? 4'h0 : hptr_r + 4'h1;
          st_r   <= MS_IDLE;
        end
        default: begin
          st_r <= MS_IDLE;
        end
      endcase
    end
  end

  // Millisecond enable from the system clock.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ms_cnt_r  <= 17'h0_0000;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (ms_cnt_r == 17'(MS_CYCLES - 1));
      ms_cnt_r  <= (ms_cnt_r == 17'(MS_CYCLES - 1)) ? 17'h0_0000
                                                   : ms_cnt_r + 17'h0_0001;
    end
  end

  wire run = cond_r & vok_r & i_enable & ~i_block;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      elap_r <= 14'h0000;
    end else if (!run) begin
      elap_r <= 14'h0000;
    end else if (ms_tick_r && elap_r != 14'h3FFF) begin
      elap_r <= elap_r + 14'h0001;
    end
  end

  wire start_nxt = run & (elap_r >= `FILTER_MS);
  wire trip_nxt  = start_nxt & ~i_start_only & (elap_r >= dly);

  // Registered outputs and their transition events.
  // start and trip outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_general_start_out <= 1'b0;
      o_general_trip_out  <= 1'b0;
      o_start_event       <= 1'b0;
      o_trip_event        <= 1'b0;
    end else begin
      o_general_start_out <= start_nxt;
      o_general_trip_out  <= trip_nxt;
      o_start_event       <= start_nxt ^ o_general_start_out;
      o_trip_event        <= trip_nxt ^ o_general_trip_out;
    end
  end

  assign o_freq_mhz   = freq_r;
  assign o_freq_valid = acc_r;
endmodule : rocof_protection

// ---- tb/rocof_protection_assertions.sv ----
// Purpose: Port assertions for the rate-of-change element.
// Assumes: MS_CYCLES equals the design instance value.
// Notes:   Time bounds allow two millisecond ticks of slack.
`timescale 1ns/1ps
module rocof_protection_checker
  import rocof_pkg::*;
#(parameter int MS_CYCLES = 50) (
  // Clock and reset.
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  // Settings and blocking.
  input wire logic        i_enable,
  input wire logic        i_start_only,
  input wire logic        i_block,
  input wire logic [13:0] i_trip_delay_ms,
  // Outputs watched.
  input wire logic        o_general_start_out,
  input wire logic        o_general_trip_out,
  input wire logic        o_start_event,
  input wire logic        o_trip_event,
  input wire freq_t       o_freq_mhz,
  input wire logic        o_freq_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Shortest run before a start may appear, in cycles.
  localparam int FILT = 98 * MS_CYCLES;
  int          run_cnt;  // Cycles the element has been free to run.
  logic [13:0] dly_ms;   // Trip delay after clamping.
  // Clamp keeps the delay inside its legal span.
  assign dly_ms = (i_trip_delay_ms < 14'h00C8) ? 14'h00C8 :
                  (i_trip_delay_ms > 14'h2710) ? 14'h2710 : i_trip_delay_ms;
  // Count enabled, unblocked cycles; saturate to avoid wrap.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) run_cnt <= 0;
    else if (!i_enable || i_block) run_cnt <= 0;
    else if (run_cnt < 32'h4000_0000) run_cnt <= run_cnt + 1;
  end
  // A change of either output level.
  sequence s_start_flip; $changed(o_general_start_out); endsequence
  sequence s_trip_flip; $changed(o_general_trip_out); endsequence
  a_start_evt_next: assert property (s_start_flip |-> o_start_event)
    else $error("start change without event");
  a_trip_evt_next: assert property (s_trip_flip |-> o_trip_event)
    else $error("trip change without event");
  a_start_evt_cause: assert property (o_start_event |->
    o_general_start_out != $past(o_general_start_out))
    else $error("start event without change");
  a_block_clears: assert property (i_block [*2] |=>
    !o_general_start_out && !o_general_trip_out)
    else $error("output high while blocked");
  a_enable_gates: assert property (!i_enable [*2] |=>
    !o_general_start_out && !o_general_trip_out)
    else $error("output high while disabled");
  a_start_only_trip: assert property (i_start_only [*2] |=>
    !o_general_trip_out) else $error("trip in start-only mode");
  a_trip_needs_start: assert property (o_general_trip_out |->
    o_general_start_out) else $error("trip without start");
  a_start_filter: assert property ($rose(o_general_start_out) |->
    run_cnt >= FILT) else $error("start before filter delay");
  a_trip_delay: assert property ($rose(o_general_trip_out) |->
    run_cnt >= (int'(dly_ms) - 2) * MS_CYCLES)
    else $error("trip before set delay");
  a_freq_zero: assert property (!o_freq_valid |-> o_freq_mhz == '0)
    else $error("frequency held while not accepted");
endmodule : rocof_protection_checker

bind rocof_protection rocof_protection_checker #(.MS_CYCLES(MS_CYCLES))
  u_checker (.i_clk, .i_reset_n, .i_enable, .i_start_only, .i_block,
  .i_trip_delay_ms, .o_general_start_out, .o_general_trip_out,
  .o_start_event, .o_trip_event, .o_freq_mhz, .o_freq_valid);

// ---- tb/rocof_trip_recorder.sv ----
// Purpose: Models the trip logic and event list fed by the element.
// Assumes: Each event pulse coincides with its new output level.
// Notes:   Counts on and off reports of each output.
`timescale 1ns/1ps
module rocof_trip_recorder (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Element outputs.
  input  wire logic i_start,
  input  wire logic i_trip,
  input  wire logic i_start_evt,
  input  wire logic i_trip_evt,
  // Event tallies.
  output int        o_start_on,
  output int        o_start_off,
  output int        o_trip_on,
  output int        o_trip_off
);
  // event list entries
  // Each event is logged with the level that it reports.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_start_on  <= 0;
      o_start_off <= 0;
      o_trip_on   <= 0;
      o_trip_off  <= 0;
    end else begin
      if (i_start_evt && i_start) o_start_on <= o_start_on + 1;
      if (i_start_evt && !i_start) o_start_off <= o_start_off + 1;
      if (i_trip_evt && i_trip) o_trip_on <= o_trip_on + 1;
      if (i_trip_evt && !i_trip) o_trip_off <= o_trip_off + 1;
    end
  end
endmodule : rocof_trip_recorder

// ---- tb/rocof_protection_tb.sv ----
// Purpose: Self-checking bench for the rate-of-change element.
// Assumes: Short millisecond tick; periods near 1000 cycles.
// Notes:   Ramps keep the period within 994..1014 cycles.
`timescale 1ns/1ps
module rocof_protection_tb;
  import rocof_pkg::*;
  localparam int MS = 50;  // Cycles per millisecond tick.
  logic               i_clk, i_reset_n, i_sample_valid, i_src_bus;
  logic               i_enable, i_start_only, i_block;
  logic signed [10:0] i_rate_threshold_setting;
  logic        [13:0] i_trip_delay_ms;
  sample_t            i_volt_line, i_volt_bus, amp;
  logic               o_general_start_out, o_general_trip_out;
  logic               o_start_event, o_trip_event, o_freq_valid, pos;
  freq_t              o_freq_mhz;
  logic               gen_on;
  int hi_len, lo_len, half_cnt, flips, ramp, cyc, t0, t1;
  int s_on, s_off, r_on, r_off, error_cnt, samples_checked;

  rocof_protection #(.MS_CYCLES(MS), .PER_MIN(700), .PER_MAX(1300))
    u_rocof_protection (.i_clk, .i_reset_n, .i_sample_valid, .i_volt_line,
    .i_volt_bus, .i_src_bus, .i_enable, .i_start_only,
    .i_rate_threshold_setting, .i_trip_delay_ms, .i_block,
    .o_general_start_out, .o_general_trip_out, .o_start_event,
    .o_trip_event, .o_freq_mhz, .o_freq_valid);
  rocof_trip_recorder u_rocof_trip_recorder (.i_clk, .i_reset_n,
    .i_start(o_general_start_out), .i_trip(o_general_trip_out),
    .i_start_evt(o_start_event), .i_trip_evt(o_trip_event),
    .o_start_on(s_on), .o_start_off(s_off), .o_trip_on(r_on),
    .o_trip_off(r_off));

  // Clock and cycle stamp.
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  // Square wave; ramp moves the high half by one cycle a period.
  always @(negedge i_clk) begin
    if (gen_on && half_cnt + 1 >= (pos ? hi_len : lo_len)) begin
      half_cnt <= 0;
      pos      <= ~pos;
      flips    <= flips + 1;
      if (!pos && ramp < 0 && hi_len + lo_len > 994) hi_len <= hi_len - 1;
      if (!pos && ramp > 0 && hi_len + lo_len < 1014) hi_len <= hi_len + 1;
    end else if (gen_on) half_cnt <= half_cnt + 1;
  end
  // Line carries the wave; the busbar stays flat, so it never crosses.
  assign i_volt_line = pos ? amp : -amp;
  assign i_volt_bus  = 16'sh0200;

  // Compare and count; report a mismatch at once.
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  // Wait for start (0), trip (1) or valid (2) to reach a level.
  task automatic wait_out(input int sel, input logic val, input int lim,
                          output int t);
    int n;
    n = 0;
    while (n < lim && ((sel == 0) ? o_general_start_out : (sel == 1) ?
           o_general_trip_out : o_freq_valid) !== val) begin
      @(negedge i_clk);
      n++;
    end
    t = cyc;
    if (n >= lim) begin
      check("wait_out", sel, 32'h0000_00FF);
      print_verdict();
    end
  endtask : wait_out

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Main sequence of scenarios.
  initial begin
    {i_clk, i_reset_n, i_src_bus, i_enable, i_start_only, i_block} = '0;
    {pos, gen_on, i_rate_threshold_setting} = '0;
    i_sample_valid = 1'b1;
    i_trip_delay_ms = 14'h0064;
    amp = 16'sh4000;
    {half_cnt, flips, ramp, cyc, error_cnt, samples_checked} = '0;
    hi_len = 507;
    lo_len = 507;
    repeat (5) @(negedge i_clk);
    i_reset_n = 1'b1;
    check("start_rst", o_general_start_out, 0); // quiet reset
    check("trip_rst", o_general_trip_out, 0); // quiet reset
    gen_on = 1'b1;
    // Too few crossings must not yet give a frequency.
    while (flips < 3) @(negedge i_clk);
    repeat (50) @(negedge i_clk);
    check("valid_early", o_freq_valid, 0); // needs four valid
    wait_out(2, 1'b1, 6000, t0); // mean period accepted
    check("freq_val", o_freq_mhz, 32'h0000_67E0); // low 20 bits of 50 MHz x 1000 over 1014
    // Flat busbar source: four timeouts drop the frequency.
    i_src_bus = 1'b1;
    repeat (7000) @(negedge i_clk);
    check("valid_bus", o_freq_valid, 0); // source switch
    check("freq_bus", o_freq_mhz, 0); // forced to zero
    i_src_bus = 1'b0;
    wait_out(2, 1'b1, 10000, t0); // line source again
    // Rising frequency, threshold zero, delay below range.
    i_enable = 1'b1;
    ramp = -1;
    wait_out(0, 1'b1, 30000, t0); // rising detected
    wait_out(1, 1'b1, 8000, t1); // trip follows
    check("gap_min", (t1 - t0 >= 98 * MS) && (t1 - t0 <= 102 * MS), 1); // onset timed
    i_start_only = 1'b1;
    repeat (3) @(negedge i_clk);
    check("trip_so", o_general_trip_out, 0); // start only
    check("start_so", o_general_start_out, 1); // start kept
    i_block = 1'b1;
    repeat (3) @(negedge i_clk);
    check("start_blk", o_general_start_out, 0); // blocking
    i_block = 1'b0;
    i_start_only = 1'b0;
    repeat (90 * MS) @(negedge i_clk);
    check("start_rerun", o_general_start_out, 0); // timer cleared
    check("ev_s", {s_on[15:0], s_off[15:0]}, 32'h0001_0001); // events
    check("ev_t", {r_on[15:0], r_off[15:0]}, 32'h0001_0001); // events
    // Falling frequency, negative threshold at its limit, low voltage first.
    i_enable = 1'b0;
    repeat (3) @(negedge i_clk);
    check("off_dis", {o_general_start_out, o_general_trip_out}, 0);
    amp = 16'sh0B00;
    i_rate_threshold_setting = 11'sh60C;
    i_trip_delay_ms = 14'h00C8;
    ramp = 1;
    i_enable = 1'b1;
    repeat (6000) @(negedge i_clk);
    check("start_lowv", o_general_start_out, 0); // below tenth
    amp = 16'sh0C00;
    wait_out(0, 1'b1, 12000, t0); // falling detected
    wait_out(1, 1'b1, 8000, t1); // trip at delay
    check("gap_neg", (t1 - t0 >= 98 * MS) && (t1 - t0 <= 102 * MS), 1); // default delay
    i_enable = 1'b0;
    repeat (3) @(negedge i_clk);
    check("off_end", {o_general_start_out, o_general_trip_out}, 0);
    check("ev_s2", {s_on[15:0], s_off[15:0]}, 32'h0002_0002); // events
    check("ev_t2", {r_on[15:0], r_off[15:0]}, 32'h0002_0002); // events
    print_verdict();
  end
endmodule : rocof_protection_tb
